// file: logic/exposure_trigger_pkg.sv
// Shared constants for the exposure and readout sequencer
package exposure_trigger_pkg;

    // ------------------------------------------------------------
    // Avalon-MM register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] EXPOSURE_OFFSET = 8'h04;
    localparam logic [7:0] READOUT_DELAY_OFFSET = 8'h08;
    localparam logic [7:0] FRAME_PERIOD_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] SOFT_TRIGGER_OFFSET = 8'h14;
    localparam logic [7:0] GEOMETRY_OFFSET = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int GEOM_LINES_LSB = 0;
    localparam int GEOM_LINE_LEN_LSB = 16;
    localparam int GEOM_FIELD_W = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    localparam logic [31:0] EXPOSURE_RESET = 32'h0000_0400;
    localparam logic [31:0] READOUT_DELAY_RESET = 32'h0000_0010;
    localparam logic [31:0] FRAME_PERIOD_RESET = 32'h0000_4000;
    localparam logic [31:0] GEOMETRY_RESET = 32'h0020_0010;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int TICK_NS = 15;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
    // One duration tick, rounded up to whole clock cycles
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Short fixed start delay for non-overlapped triggers, in ticks
    localparam logic [31:0] TRIG_START_DELAY = 32'h0000_0002;
    localparam int LINE_GAP_CYCLES = 4;

    typedef enum logic {
        MODE_FREE_RUN,
        MODE_TRIGGERED
    } capture_mode_t;

endpackage

// file: logic/exposure_trigger_control.sv
// Exposure, trigger and readout sequencer with Avalon-MM control registers
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

// Notes on behaviour
// (RL1) Two modes: free-run and triggered
// (RL2) Free-run exposes and reads out periodically
// (RL3) Triggered mode waits for a trigger
// (RL4) Line flag per line, frame flag whole frame
// (RL5) Free-run exposure from written register, counted
// (RL6) Trigger rising edge starts integration
// (RL7) Trigger falling edge ends integration, starts readout
// (RL8) Pulse width sets each frame's exposure
// (RL9) Overlapped rise waits for line flag fall
// (RL10) Idle rise starts after short fixed delay
// (RL11) Source drops trigger only after frame ends
// (RL12) Software trigger alternative to pin
// (RL13) Programmable delay before data transfer
// (RL14) Durations timed from system clock ticks
// (RL15) Durations quantised to 15 ns steps; the tick here rounds up to 2 clock cycles (20 ns)
// (RL16) Durations loaded into down-counters per phase
// (RL17) Reset: free-run, qualifiers low
module exposure_trigger_control (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic trigger_i,
    output logic exposing_o,
    output logic line_valid_flag_o,
    output logic frame_valid_flag_o
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_EXPOSE,
        ST_DELAY,
        ST_READ
    } seq_state_t;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] exposure_ticks;
    logic [31:0] readout_delay_ticks;
    logic [31:0] frame_period_ticks;
    logic [31:0] geometry;
    logic soft_trig_req;
    logic bus_ack;
    logic overrun;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
        return addr == offs;
    endfunction

    logic wr_take;
    logic rd_take;
    assign wr_take = avs_write_i && !avs_waitrequest_o;
    assign rd_take = avs_read_i && !avs_waitrequest_o;

    // One wait cycle per access: waitrequest drops the cycle after the request rises
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read_i || avs_write_i) && !bus_ack;
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !bus_ack);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl <= exposure_trigger_pkg::CTRL_RESET; // RL17
            exposure_ticks <= exposure_trigger_pkg::EXPOSURE_RESET;
            readout_delay_ticks <= exposure_trigger_pkg::READOUT_DELAY_RESET;
            frame_period_ticks <= exposure_trigger_pkg::FRAME_PERIOD_RESET;
            geometry <= exposure_trigger_pkg::GEOMETRY_RESET;
        end else if (wr_take) begin
            if (hit(avs_address_i, exposure_trigger_pkg::CTRL_OFFSET)) begin
                ctrl <= merge_bytes(ctrl, avs_writedata_i, avs_byteenable_i) & 32'h0000_0003; // RL1
            end
            if (hit(avs_address_i, exposure_trigger_pkg::EXPOSURE_OFFSET)) begin
                exposure_ticks <= merge_bytes(exposure_ticks, avs_writedata_i, avs_byteenable_i); // RL5
            end
            if (hit(avs_address_i, exposure_trigger_pkg::READOUT_DELAY_OFFSET)) begin
                readout_delay_ticks <= merge_bytes(readout_delay_ticks, avs_writedata_i, avs_byteenable_i); // RL13
            end
            if (hit(avs_address_i, exposure_trigger_pkg::FRAME_PERIOD_OFFSET)) begin
                frame_period_ticks <= merge_bytes(frame_period_ticks, avs_writedata_i, avs_byteenable_i);
            end
            if (hit(avs_address_i, exposure_trigger_pkg::GEOMETRY_OFFSET)) begin
                geometry <= merge_bytes(geometry, avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    // ------------------------------------------------------------
    // Trigger pin synchroniser and edge detect
    // ------------------------------------------------------------
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= trigger_i;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    logic trig_rise;
    logic trig_fall;
    assign trig_rise = trig_sync && !trig_prev; // RL6
    assign trig_fall = !trig_sync && trig_prev; // RL7

    // ------------------------------------------------------------
    // Tick prescaler: one tick per TICK_CYCLES (2) clock cycles, 20 ns steps
    // ------------------------------------------------------------
    logic [3:0] tick_cnt;
    logic tick;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt <= 4'h0;
            tick <= 1'b0;
        end else if (tick_cnt == 4'(exposure_trigger_pkg::TICK_CYCLES - 1)) begin // RL14 RL15
            tick_cnt <= 4'h0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 4'h1;
            tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    seq_state_t state;
    logic [31:0] phase_cnt;
    logic [31:0] period_cnt;
    logic [15:0] line_idx;
    logic [15:0] pix_cnt;
    logic in_gap;
    logic pending_rise;
    logic pulse_mode;
    logic line_fall;
    logic trig_mode;
    logic [15:0] lines_per_frame;
    logic [15:0] line_len;

    assign trig_mode = ctrl[exposure_trigger_pkg::CTRL_MODE_BIT];
    assign lines_per_frame = geometry[exposure_trigger_pkg::GEOM_LINES_LSB +: exposure_trigger_pkg::GEOM_FIELD_W];
    assign line_len = geometry[exposure_trigger_pkg::GEOM_LINE_LEN_LSB +: exposure_trigger_pkg::GEOM_FIELD_W];
    assign line_fall = frame_valid_flag_o && !in_gap && (pix_cnt == line_len - 16'h1); // RL9

    logic soft_trig;
    assign soft_trig = wr_take && hit(avs_address_i, exposure_trigger_pkg::SOFT_TRIGGER_OFFSET)
                       && avs_writedata_i[0];

    // Software trigger: timed exposure from the register, since there is no pulse width
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_trig_req <= 1'b0;
        end else if (soft_trig) begin
            soft_trig_req <= 1'b1; // RL12
        end else if (state == ST_ARM || (state == ST_IDLE && trig_mode && !frame_valid_flag_o)) begin
            soft_trig_req <= 1'b0;
        end
    end

    // Free-run frame period counter, restarts on each exposure start
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period_cnt <= 32'h0;
        end else if (state == ST_ARM || (state == ST_IDLE && !trig_mode && period_cnt == 32'h0)) begin
            period_cnt <= frame_period_ticks; // RL2
        end else if (tick && period_cnt != 32'h0) begin
            period_cnt <= period_cnt - 32'h1;
        end
    end

    logic enable;
    assign enable = ctrl[exposure_trigger_pkg::CTRL_ENABLE_BIT];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            phase_cnt <= 32'h0;
            pending_rise <= 1'b0;
            pulse_mode <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (trig_mode && trig_rise && frame_valid_flag_o) begin
                pending_rise <= 1'b1; // RL9
            end else if (line_fall || !frame_valid_flag_o) begin
                pending_rise <= 1'b0;
            end
            if (trig_fall && frame_valid_flag_o && state == ST_EXPOSE) begin
                overrun <= 1'b1; // RL11
            end else if (rd_take && hit(avs_address_i, exposure_trigger_pkg::STATUS_OFFSET)) begin
                overrun <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (enable && !trig_mode && period_cnt == 32'h0 && !frame_valid_flag_o) begin
                        phase_cnt <= exposure_ticks; // RL5 RL16
                        pulse_mode <= 1'b0;
                        state <= ST_EXPOSE; // RL2
                    end else if (enable && trig_mode && trig_rise && !frame_valid_flag_o) begin
                        phase_cnt <= exposure_trigger_pkg::TRIG_START_DELAY; // RL10
                        pulse_mode <= 1'b1;
                        state <= ST_ARM; // RL3
                    end else if (enable && trig_mode && soft_trig_req && !frame_valid_flag_o) begin
                        phase_cnt <= exposure_trigger_pkg::TRIG_START_DELAY;
                        pulse_mode <= 1'b0;
                        state <= ST_ARM;
                    end else if (enable && trig_mode && (pending_rise || trig_rise) && line_fall) begin
                        phase_cnt <= 32'h0; // RL9
                        pulse_mode <= 1'b1;
                        state <= ST_ARM;
                    end
                end
                ST_ARM: begin
                    if (phase_cnt == 32'h0) begin
                        phase_cnt <= exposure_ticks; // RL16
                        state <= ST_EXPOSE; // RL6
                    end else if (tick) begin
                        phase_cnt <= phase_cnt - 32'h1;
                    end
                end
                ST_EXPOSE: begin
                    if (pulse_mode) begin
                        if (!trig_sync && !frame_valid_flag_o) begin
                            phase_cnt <= readout_delay_ticks; // RL7 RL8 RL13
                            state <= ST_DELAY;
                        end
                    end else if (phase_cnt == 32'h0) begin
                        phase_cnt <= readout_delay_ticks; // RL13 RL16
                        state <= ST_DELAY;
                    end else if (tick) begin
                        phase_cnt <= phase_cnt - 32'h1;
                    end
                end
                ST_DELAY: begin
                    if (phase_cnt == 32'h0 && !frame_valid_flag_o) begin
                        state <= ST_READ;
                    end else if (tick && phase_cnt != 32'h0) begin
                        phase_cnt <= phase_cnt - 32'h1;
                    end
                end
                ST_READ: begin
                    state <= ST_IDLE; // Readout runs on while the next trigger is taken
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Readout framing: line and frame qualifiers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_valid_flag_o <= 1'b0; // RL17
            line_valid_flag_o <= 1'b0;
            line_idx <= 16'h0;
            pix_cnt <= 16'h0;
            in_gap <= 1'b0;
        end else if (state == ST_READ && !frame_valid_flag_o) begin
            frame_valid_flag_o <= 1'b1; // RL4
            line_valid_flag_o <= 1'b1;
            line_idx <= 16'h0;
            pix_cnt <= 16'h0;
            in_gap <= 1'b0;
        end else if (frame_valid_flag_o) begin
            if (!in_gap) begin
                if (pix_cnt == line_len - 16'h1) begin
                    line_valid_flag_o <= 1'b0; // RL4
                    in_gap <= 1'b1;
                    pix_cnt <= 16'h0;
                end else begin
                    pix_cnt <= pix_cnt + 16'h1;
                end
            end else if (pix_cnt == 16'(exposure_trigger_pkg::LINE_GAP_CYCLES - 1)) begin
                pix_cnt <= 16'h0;
                in_gap <= 1'b0;
                if (line_idx == lines_per_frame - 16'h1) begin
                    frame_valid_flag_o <= 1'b0; // RL4
                end else begin
                    line_idx <= line_idx + 16'h1;
                    line_valid_flag_o <= 1'b1;
                end
            end else begin
                pix_cnt <= pix_cnt + 16'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            exposing_o <= 1'b0;
        end else begin
            // Timed exposure keeps its last tick, so it lasts the full count
            exposing_o <= (state == ST_EXPOSE) && !(pulse_mode && !trig_sync && !frame_valid_flag_o);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= exposure_trigger_pkg::UNMAPPED_READ;
        end else if (avs_read_i && !bus_ack) begin
            case (avs_address_i)
                exposure_trigger_pkg::CTRL_OFFSET: avs_readdata_o <= ctrl;
                exposure_trigger_pkg::EXPOSURE_OFFSET: avs_readdata_o <= exposure_ticks;
                exposure_trigger_pkg::READOUT_DELAY_OFFSET: avs_readdata_o <= readout_delay_ticks;
                exposure_trigger_pkg::FRAME_PERIOD_OFFSET: avs_readdata_o <= frame_period_ticks;
                exposure_trigger_pkg::GEOMETRY_OFFSET: avs_readdata_o <= geometry;
                exposure_trigger_pkg::STATUS_OFFSET: begin
                    avs_readdata_o <= {24'h0, overrun, pending_rise, soft_trig_req, frame_valid_flag_o,
                                       line_valid_flag_o, state};
                end
                default: avs_readdata_o <= exposure_trigger_pkg::UNMAPPED_READ;
            endcase
        end
    end

endmodule

// file: dv/trigger_source_model.sv
// Behavioural model of the external trigger source
`timescale 1ns/1ps
module trigger_source_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic fire_i,
    input wire logic [15:0] width_i,
    input wire logic frame_valid_flag_i,
    output logic trigger_o
);
    // ------
    // Pulse generator
    // ------
    logic [15:0] hold_cnt;

    // Width only sets the minimum; the fall waits for the frame to end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trigger_o <= 1'b0;
            hold_cnt <= 16'h0000;
        end else if (fire_i) begin
            trigger_o <= 1'b1;
            hold_cnt <= width_i;
        end else if (hold_cnt != 16'h0000) begin
            hold_cnt <= hold_cnt - 16'h0001;
        end else if (!frame_valid_flag_i) begin
            trigger_o <= 1'b0;
        end
    end
endmodule

// file: dv/exposure_trigger_control_asserts.sv
// Port-level checker for the exposure and readout sequencer
`timescale 1ns/1ps
module exposure_trigger_control_checker (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic trigger_i,
    input wire logic exposing_o,
    input wire logic line_valid_flag_o,
    input wire logic frame_valid_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ------
    // Mode shadow, followed from completed control writes
    // ------
    logic trig_mode;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trig_mode <= 1'b0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == exposure_trigger_pkg::CTRL_OFFSET) begin
            trig_mode <= avs_writedata_i[exposure_trigger_pkg::CTRL_MODE_BIT];
        end
    end

    sequence s_idle_rise;
        trig_mode && $rose(trigger_i) && !frame_valid_flag_o && !exposing_o;
    endsequence
    sequence s_pulse_fall;
        trig_mode && $fell(trigger_i) && exposing_o && !frame_valid_flag_o;
    endsequence

    // ------
    // Properties
    // ------
    a_reset_quiet: assert property (
        $rose(resetn_i) |-> !exposing_o && !frame_valid_flag_o && !line_valid_flag_o)
        else $error("flags not low after reset");
    a_line_in_frame: assert property (
        line_valid_flag_o |-> frame_valid_flag_o) else $error("line flag outside frame");
    a_frame_opens_line: assert property (
        $rose(frame_valid_flag_o) |-> line_valid_flag_o) else $error("frame opened without line");
    a_frame_closes_gap: assert property (
        $fell(frame_valid_flag_o) |-> !line_valid_flag_o && !$past(line_valid_flag_o))
        else $error("frame closed inside a line");
    a_wait_single: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
    a_bus_answer: assert property (
        (avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o) else $error("bus access not answered");
    a_idle_start: assert property (
        s_idle_rise |-> ##[4:16] exposing_o) else $error("idle trigger did not start exposure");
    a_pulse_ends: assert property (
        s_pulse_fall |-> ##[1:6] !exposing_o) else $error("trigger fall did not end exposure");
    a_overlap_align: assert property (
        $rose(exposing_o) && frame_valid_flag_o |-> !line_valid_flag_o) else $error("overlap start not aligned");
    a_delay_first: assert property (
        $fell(exposing_o) |-> !frame_valid_flag_o [*3]) else $error("readout without delay");
endmodule

bind exposure_trigger_control exposure_trigger_control_checker u_chk (.clk_i, .resetn_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .trigger_i, .exposing_o, .line_valid_flag_o, .frame_valid_flag_o);

// file: dv/exposure_trigger_control_tb_top.sv
// Self-checking testbench for the exposure and readout sequencer
`timescale 1ns/1ps
module exposure_trigger_control_tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic fire = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [15:0] width = 16'h0;
    logic [31:0] avs_readdata_o, rd;
    logic avs_waitrequest_o, trigger_i, exposing_o, line_valid_flag_o, frame_valid_flag_o;
    int num_errors = 0, n_tests = 0, n;
    int len_q[2], gap_q[2];
    time t0;
    logic [7:0] offs[6] = '{exposure_trigger_pkg::CTRL_OFFSET, exposure_trigger_pkg::EXPOSURE_OFFSET,
        exposure_trigger_pkg::READOUT_DELAY_OFFSET, exposure_trigger_pkg::FRAME_PERIOD_OFFSET,
        exposure_trigger_pkg::GEOMETRY_OFFSET, 8'h1C};
    logic [31:0] rsts[6] = '{exposure_trigger_pkg::CTRL_RESET, exposure_trigger_pkg::EXPOSURE_RESET,
        exposure_trigger_pkg::READOUT_DELAY_RESET, exposure_trigger_pkg::FRAME_PERIOD_RESET,
        exposure_trigger_pkg::GEOMETRY_RESET, exposure_trigger_pkg::UNMAPPED_READ};

    always #5 clk_i = ~clk_i;

    exposure_trigger_control u_dut (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .trigger_i,
        .exposing_o, .line_valid_flag_o, .frame_valid_flag_o);
    trigger_source_model u_src (.clk_i, .resetn_i, .fire_i(fire), .width_i(width),
        .frame_valid_flag_i(frame_valid_flag_o), .trigger_o(trigger_i));

    // ------
    // Tasks
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 100);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (k >= 100) begin
            chk(32'h0, 32'h1);
            results();
        end
    endtask

    function automatic logic sig(input int s);
        return s == 0 ? exposing_o : (s == 1 ? frame_valid_flag_o : line_valid_flag_o);
    endfunction

    // Counts cycles until the chosen output reaches the level; long bound covers a full default period
    task automatic wait_sig(input int s, input logic v, output int c);
        c = 0;
        do begin
            @(negedge clk_i);
            c++;
        end while (sig(s) !== v && c < 40000);
        if (c >= 40000) begin
            chk(32'h0, 32'h1);
            results();
        end
    endtask

    task automatic pulse(input logic [15:0] w);
        @(posedge clk_i);
        fire <= 1'b1;
        width <= w;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    task results;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #1_000_000;
        num_errors++;
        results();
    end

    // ------
    // Sequence
    // ------
    initial begin
        repeat (16) @(posedge clk_i);
        chk({29'h0, frame_valid_flag_o, line_valid_flag_o, exposing_o}, 32'h0);
        resetn_i <= 1'b1;
        bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 32'h0);
            chk(rd, rsts[i]);
        end
        bus(1'b1, exposure_trigger_pkg::GEOMETRY_OFFSET, 32'h0008_0002);
        bus(1'b1, exposure_trigger_pkg::EXPOSURE_OFFSET, 32'h0000_0010);
        bus(1'b1, exposure_trigger_pkg::FRAME_PERIOD_OFFSET, 32'h0000_0100);
        bus(1'b1, exposure_trigger_pkg::READOUT_DELAY_OFFSET, 32'h0000_0004);
        bus(1'b0, exposure_trigger_pkg::EXPOSURE_OFFSET, 32'h0);
        chk(rd, 32'h0000_0010);
        wait_sig(1, 1'b1, n);
        wait_sig(1, 1'b0, n);
        wait_sig(0, 1'b1, n);
        t0 = $time;
        wait_sig(0, 1'b0, n);
        chk(32'(n), 32'h20);
        wait_sig(1, 1'b1, n);
        for (int i = 0; i < 2; i++) begin
            wait_sig(2, 1'b0, n);
            chk(32'(n), 32'h8);
            if (i == 0) wait_sig(2, 1'b1, n);
            else wait_sig(1, 1'b0, n);
            chk(32'(n), 32'h4);
        end
        wait_sig(0, 1'b1, n);
        chk(32'(($time - t0) / 10), 32'h200);
        bus(1'b1, exposure_trigger_pkg::CTRL_OFFSET, 32'h0000_0003);
        repeat (700) @(negedge clk_i);
        rd = 32'h0;
        repeat (300) begin
            @(negedge clk_i);
            rd[0] = rd[0] | exposing_o;
        end
        chk(rd, 32'h0);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, exposure_trigger_pkg::READOUT_DELAY_OFFSET, 32'(4 + 4 * i));
            pulse(16'(40 + 40 * i));
            wait_sig(0, 1'b1, n);
            wait_sig(0, 1'b0, len_q[i]);
            wait_sig(1, 1'b1, gap_q[i]);
            wait_sig(1, 1'b0, n);
        end
        chk(32'(len_q[1] - len_q[0]), 32'h28);
        chk(32'(gap_q[1] - gap_q[0]), 32'h8);
        pulse(16'h1E);
        wait_sig(1, 1'b1, n);
        pulse(16'h4);
        wait_sig(0, 1'b1, n);
        chk({30'h0, frame_valid_flag_o, line_valid_flag_o}, 32'h2);
        wait_sig(1, 1'b0, n);
        wait_sig(0, 1'b0, n);
        wait_sig(1, 1'b1, n);
        wait_sig(1, 1'b0, n);
        bus(1'b1, exposure_trigger_pkg::SOFT_TRIGGER_OFFSET, 32'h0000_0001);
        wait_sig(0, 1'b1, n);
        wait_sig(0, 1'b0, n);
        chk(32'(n), 32'h20);
        wait_sig(1, 1'b1, n);
        wait_sig(1, 1'b0, n);
        bus(1'b1, exposure_trigger_pkg::CTRL_OFFSET, 32'h0000_0001);
        bus(1'b1, exposure_trigger_pkg::SOFT_TRIGGER_OFFSET, 32'h0000_0001);
        rd = 32'h0;
        repeat (100) begin
            @(negedge clk_i);
            rd[0] = rd[0] | exposing_o;
        end
        chk(rd, 32'h0);
        results();
    end
endmodule
